// *** imb_pkg.sv ***
/*
  imb_pkg: constants and carrier types for the i2c mailbox and event block.
  assumes: a single 10 mhz device clock and a 17-bit register bus offset.
*/
package imb_pkg;

  // register bus offset width, wide enough for the 0x1d3xx window
  localparam int ADDR_W = 17;

  // register bus offsets
  localparam logic [ADDR_W-1:0] OFS_OUTBOUND = 17'h1d290;
  localparam logic [ADDR_W-1:0] OFS_INBOUND = 17'h1d294;
  localparam logic [ADDR_W-1:0] OFS_EV_SUMMARY = 17'h1d300;
  localparam logic [ADDR_W-1:0] OFS_EV_SNAPSHOT = 17'h1d304;

  // i2c slave address window of each mailbox (first and last byte)
  localparam logic [7:0] I2C_OUT_FIRST = 8'h90;
  localparam logic [7:0] I2C_OUT_LAST = 8'h93;
  localparam logic [7:0] I2C_IN_FIRST = 8'h94;
  localparam logic [7:0] I2C_IN_LAST = 8'h97;

  // reset values
  localparam logic [31:0] MBOX_RESET = 32'h0000_0000;
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // implemented event bits; reserved positions always read as zero
  localparam logic [31:0] EVENT_VALID = 32'hfcfa_7bee;

  // event bit positions generated inside this block
  localparam int EV_REG_WRITE = 1;
  localparam int EV_REG_READ = 2;
  localparam int EV_XFER_DONE = 3;
  localparam int EV_IN_WRITE = 8;
  localparam int EV_OUT_READ = 9;

  // a byte on the i2c link is eight bits, then the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // register bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } imb_reg_req_t;

  // register bus answer, one cycle after the request
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } imb_reg_rsp_t;

  // mailbox flags and interrupt pulses
  typedef struct packed {
    logic outgoing_full_flag;
    logic incoming_full_flag;
    logic outgoing_drained_irq;
    logic incoming_loaded_irq;
  } imb_mbox_stat_t;

endpackage

// *** imb_mailbox.sv ***
/*
  imb_mailbox: outgoing and incoming 32-bit mailboxes shared between the
  register bus and an external i2c master, a small i2c slave engine that
  reaches them, and the event / event snapshot registers.
  assumes: scl and sda arrive asynchronously; sda is open-drain, resolved outside;
  capture, status clear, mask and soft reset come from logic on the same clock.
*/
// Function
// - outgoing mailbox bus read/write, i2c read-only
// - outgoing mailbox bytes at i2c 0x90-0x93
// - software write sets outgoing-full flag
// - completed read clears flag, drained irq if set
// - read complete at stop after mailbox byte
// - incoming mailbox bus read-only, i2c writable
// - incoming mailbox bytes at i2c 0x94-0x97
// - incoming write sets full flag and irq
// - software read of incoming clears full flag
// - summary bit is new OR snapshot bit
// - interrupt status read captures a snapshot
// - summary write-one clears snapshot and new
// - snapshot write-one clears only snapshot bit
// - status write-one clears enabled snapshot bits
// - summary ANDed with mask drives status
// - soft reset clears and blocks all events
// - event 1 on register-write transaction done
// - event 2 on register-read transaction done
// - event 3 on addressed transaction done
// - event 8 on incoming mailbox write done
// - event 9 on outgoing read while full
module imb_mailbox import imb_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a  // arbitrary default slave address
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic block_soft_reset_i,
  // register bus
  input wire imb_reg_req_t reg_req_i,
  output imb_reg_rsp_t reg_rsp_o,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // interrupt status side
  input wire logic snap_capture_i,
  input wire logic [31:0] int_stat_clear_i,
  input wire logic [31:0] event_mask_reg_i,
  input wire logic [31:0] ext_event_i,
  // flags and enabled events
  output imb_mbox_stat_t mbox_stat_o,
  output logic [31:0] event_enabled_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } imb_state_t;

  // byte of a mailbox word at a given byte index; index 0 is the top byte
  function automatic logic [7:0] mbox_byte(input logic [31:0] word, input logic [1:0] idx);
    return word[{~idx, 3'h0} +: 8];
  endfunction

  // true when an i2c pointer falls inside an inclusive window
  function automatic logic in_window(input logic [7:0] p, input logic [7:0] lo, input logic [7:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction

  // pin synchronisers and delayed copies for edge finding
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  // slave engine state
  imb_state_t state, after_ack;
  logic [3:0] bit_cnt;     // bits seen in the current byte
  logic [7:0] shreg;       // receive or transmit shift register
  logic [7:0] ptr;         // i2c register pointer, auto increments
  logic [7:0] acc_ptr;     // pointer of the byte just accessed
  logic [7:0] wr_data;     // byte written by the master
  logic wr_stb, rd_stb, match_stb;
  logic sda_oe, sda_out;
  // per-transaction history, cleared at start
  logic out_touched, in_touched, reg_wr_seen, reg_rd_seen, addressed;
  // storage
  logic [31:0] out_mbox, in_mbox;
  logic [31:0] new_event, snap_event, event_enabled;
  imb_mbox_stat_t mbox_stat;
  imb_reg_rsp_t reg_rsp;
  // combinational helpers
  logic start_det, stop_det, scl_rise, scl_fall, clr_all;
  logic bus_rd, bus_wr;
  logic [7:0] rd_byte;
  logic [31:0] hw_set, sum_clr, snap_clr;

  // block-wide clear: hard reset or soft reset of the i2c block
  assign clr_all = reset_i || block_soft_reset_i;
  assign bus_rd = reg_req_i.valid && !reg_req_i.write;
  assign bus_wr = reg_req_i.valid && reg_req_i.write;

  // two flip-flops per pin, then one more stage for edge detection;
  // reset to the idle high level so that no false edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      {scl_d, scl_s2, scl_s1} <= 3'h7;
      {sda_d, sda_s2, sda_s1} <= 3'h7;
    end else begin
      {scl_d, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_i};
      {sda_d, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_i};
    end
  end

  // start and stop are sda edges while scl stays high
  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;

  // byte returned to the master; addresses outside the mailboxes read zero
  always_comb begin
    rd_byte = BYTE_RESET;
    if (in_window(ptr, I2C_OUT_FIRST, I2C_OUT_LAST)) begin
      rd_byte = mbox_byte(out_mbox, ptr[1:0]);
    end else if (in_window(ptr, I2C_IN_FIRST, I2C_IN_LAST)) begin
      rd_byte = mbox_byte(in_mbox, ptr[1:0]);
    end
  end

  // i2c slave engine: address, pointer, then data bytes with auto increment
  always_ff @(posedge ref_clk_i) begin
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    match_stb <= 1'b0;
    if (clr_all) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= BYTE_RESET;
      ptr <= BYTE_RESET;
      acc_ptr <= BYTE_RESET;
      wr_data <= BYTE_RESET;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      // stop always releases the line
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      // start or repeated start: expect the address byte
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            // sample on the rising edge, data is stable while scl is high
            shreg <= {shreg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            state <= ST_ACK;
            sda_oe <= 1'b1;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                match_stb <= 1'b1;
                after_ack <= shreg[0] ? ST_RDATA : ST_PTR;
              end else begin
                // not for us: stay off the line until the next start
                state <= ST_IDLE;
                sda_oe <= 1'b0;
              end
            end else if (state == ST_PTR) begin
              ptr <= shreg;
              after_ack <= ST_WDATA;
            end else begin
              wr_stb <= 1'b1;
              acc_ptr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
              after_ack <= ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= after_ack;
            bit_cnt <= 4'h0;
            if (after_ack == ST_RDATA) begin
              // first read byte goes out right after the address ack
              shreg <= rd_byte;
              sda_oe <= !rd_byte[7];
              rd_stb <= 1'b1;
              acc_ptr <= ptr;
              ptr <= ptr + 8'h01;
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              // let the master drive its acknowledge
              sda_oe <= 1'b0;
              state <= ST_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= !shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s2) begin
            // nack: the master wants no more data
            state <= ST_IDLE;
          end else if (scl_fall) begin
            state <= ST_RDATA;
            bit_cnt <= 4'h0;
            shreg <= rd_byte;
            sda_oe <= !rd_byte[7];
            rd_stb <= 1'b1;
            acc_ptr <= ptr;
            ptr <= ptr + 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain pin: only ever pulls low, the enable carries the data
  always_ff @(posedge ref_clk_i) begin
    sda_out <= 1'b0;
  end
  assign sda_o = sda_out;
  assign sda_oe_o = sda_oe;

  // history of the transaction since the last start; consumed at stop so that
  // a later stop without a start counts nothing
  always_ff @(posedge ref_clk_i) begin
    if (clr_all || start_det || stop_det) begin
      out_touched <= 1'b0;
      in_touched <= 1'b0;
      reg_wr_seen <= 1'b0;
      reg_rd_seen <= 1'b0;
      addressed <= 1'b0;
    end else begin
      out_touched <= out_touched || (rd_stb && in_window(acc_ptr, I2C_OUT_FIRST, I2C_OUT_LAST));
      in_touched <= in_touched || (wr_stb && in_window(acc_ptr, I2C_IN_FIRST, I2C_IN_LAST));
      reg_wr_seen <= reg_wr_seen || wr_stb;
      reg_rd_seen <= reg_rd_seen || rd_stb;
      addressed <= addressed || match_stb;
    end
  end

  // mailbox storage: outgoing from the bus only, incoming from i2c only
  always_ff @(posedge ref_clk_i) begin
    if (clr_all) begin
      out_mbox <= MBOX_RESET;
      in_mbox <= MBOX_RESET;
    end else begin
      if (bus_wr && reg_req_i.addr == OFS_OUTBOUND) begin
        out_mbox <= reg_req_i.wdata;
      end
      // i2c writes into the outgoing window are dropped; pointer bits pick the byte
      if (wr_stb && in_window(acc_ptr, I2C_IN_FIRST, I2C_IN_LAST)) begin
        in_mbox[{~acc_ptr[1:0], 3'h0} +: 8] <= wr_data;
      end
    end
  end

  // mailbox flags; when a set meets a clear in one cycle the set wins
  always_ff @(posedge ref_clk_i) begin
    if (clr_all) begin
      mbox_stat <= '0;
    end else begin
      mbox_stat.outgoing_drained_irq <= stop_det && out_touched && mbox_stat.outgoing_full_flag;
      mbox_stat.incoming_loaded_irq <= stop_det && in_touched;
      if (bus_wr && reg_req_i.addr == OFS_OUTBOUND) begin
        mbox_stat.outgoing_full_flag <= 1'b1;
      end else if (stop_det && out_touched) begin
        mbox_stat.outgoing_full_flag <= 1'b0;
      end
      if (stop_det && in_touched) begin
        mbox_stat.incoming_full_flag <= 1'b1;
      end else if (bus_rd && reg_req_i.addr == OFS_INBOUND) begin
        mbox_stat.incoming_full_flag <= 1'b0;
      end
    end
  end
  assign mbox_stat_o = mbox_stat;

  // events raised this cycle, from outside and from the slave engine
  always_comb begin
    hw_set = ext_event_i;
    if (stop_det) begin
      hw_set[EV_REG_WRITE] = ext_event_i[EV_REG_WRITE] || reg_wr_seen;
      hw_set[EV_REG_READ] = ext_event_i[EV_REG_READ] || reg_rd_seen;
      hw_set[EV_XFER_DONE] = ext_event_i[EV_XFER_DONE] || addressed;
      hw_set[EV_IN_WRITE] = ext_event_i[EV_IN_WRITE] || in_touched;
      hw_set[EV_OUT_READ] = ext_event_i[EV_OUT_READ] || (out_touched && mbox_stat.outgoing_full_flag);
    end
    hw_set = hw_set & EVENT_VALID;
  end

  // write-one-to-clear masks from the three clearing paths
  always_comb begin
    sum_clr = '0;
    snap_clr = int_stat_clear_i & event_mask_reg_i;
    if (bus_wr && reg_req_i.addr == OFS_EV_SUMMARY) begin
      sum_clr = reg_req_i.wdata;
    end
    if (bus_wr && reg_req_i.addr == OFS_EV_SNAPSHOT) begin
      snap_clr = snap_clr | reg_req_i.wdata;
    end
    snap_clr = snap_clr | sum_clr;
  end

  // new-event and snapshot registers; a capture moves new events across
  always_ff @(posedge ref_clk_i) begin
    if (clr_all) begin
      new_event <= EVENT_RESET;
      snap_event <= EVENT_RESET;
    end else if (snap_capture_i) begin
      // events raised during the capture stay new for the next snapshot
      snap_event <= (snap_event & ~snap_clr) | new_event;
      new_event <= hw_set;
    end else begin
      snap_event <= snap_event & ~snap_clr;
      new_event <= (new_event & ~sum_clr) | hw_set;
    end
  end

  // enabled events feed the interrupt status; lags the events by one cycle
  always_ff @(posedge ref_clk_i) begin
    if (clr_all) begin
      event_enabled <= EVENT_RESET;
    end else begin
      event_enabled <= (new_event | snap_event) & event_mask_reg_i;
    end
  end
  assign event_enabled_o = event_enabled;

  // register bus answer, one cycle after each request; unmapped reads zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.valid <= reg_req_i.valid;
      reg_rsp.rdata <= '0;
      if (bus_rd) begin
        case (reg_req_i.addr)
          OFS_OUTBOUND: reg_rsp.rdata <= out_mbox;
          OFS_INBOUND: reg_rsp.rdata <= in_mbox;
          OFS_EV_SUMMARY: reg_rsp.rdata <= new_event | snap_event;
          OFS_EV_SNAPSHOT: reg_rsp.rdata <= snap_event;
          default: reg_rsp.rdata <= '0;
        endcase
      end
    end
  end
  assign reg_rsp_o = reg_rsp;

endmodule

// *** imb_mailbox_sva.sv ***
/*
  imb_mailbox_sva: port-level timing checks for the mailbox and event block.
  assumes: bound to every imb_mailbox, one clock domain, reset_i synchronous.
*/
module imb_mailbox_sva import imb_pkg::*; (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic block_soft_reset_i,
  // register bus and status side
  input wire imb_reg_req_t reg_req_i,
  input wire imb_reg_rsp_t reg_rsp_o,
  input wire logic [31:0] event_mask_reg_i,
  input wire imb_mbox_stat_t mbox_stat_o,
  input wire logic [31:0] event_enabled_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // software write to the outbound word, soft reset quiet
  sequence s_out_wr;
    reg_req_i.valid && reg_req_i.write && reg_req_i.addr == OFS_OUTBOUND && !block_soft_reset_i;
  endsequence
  // software read of the inbound word
  sequence s_in_rd;
    reg_req_i.valid && !reg_req_i.write && reg_req_i.addr == OFS_INBOUND && !block_soft_reset_i;
  endsequence
  // soft reset held for two edges, long enough to flush the enabled view
  sequence s_soft_hold;
    block_soft_reset_i ##1 block_soft_reset_i;
  endsequence
  a_rsp_one_cycle: assert property (reg_rsp_o.valid == $past(reg_req_i.valid))
    else $error("register answer not one cycle after request");
  a_out_flag_set: assert property (s_out_wr |=> mbox_stat_o.outgoing_full_flag)
    else $error("outgoing flag not set by software write");
  a_drain_was_full: assert property (mbox_stat_o.outgoing_drained_irq |->
    $past(mbox_stat_o.outgoing_full_flag) && (!mbox_stat_o.outgoing_full_flag ||
    $past(reg_req_i.valid && reg_req_i.write && reg_req_i.addr == OFS_OUTBOUND)))
    else $error("drained pulse without a full mailbox");
  a_drain_one_pulse: assert property (mbox_stat_o.outgoing_drained_irq |=> !mbox_stat_o.outgoing_drained_irq)
    else $error("drained pulse longer than one cycle");
  a_load_sets_flag: assert property (mbox_stat_o.incoming_loaded_irq |-> mbox_stat_o.incoming_full_flag)
    else $error("loaded pulse without incoming flag");
  a_load_once_only: assert property (mbox_stat_o.incoming_loaded_irq |=> !mbox_stat_o.incoming_loaded_irq)
    else $error("loaded pulse repeated");
  a_in_read_clears: assert property (s_in_rd |=>
    !mbox_stat_o.incoming_full_flag || mbox_stat_o.incoming_loaded_irq)
    else $error("incoming flag kept after software read");
  a_soft_clears_all: assert property (s_soft_hold |=> event_enabled_o == 32'h0 && mbox_stat_o == '0)
    else $error("soft reset left events or flags");
  a_enable_masked: assert property ((event_enabled_o & ~$past(event_mask_reg_i)) == 32'h0)
    else $error("masked event reached status");
  a_reserved_zero: assert property ((event_enabled_o & ~EVENT_VALID) == 32'h0)
    else $error("reserved event bit set");
endmodule

bind imb_mailbox imb_mailbox_sva chk_u (
  .ref_clk_i(ref_clk_i),
  .reset_i(reset_i),
  .block_soft_reset_i(block_soft_reset_i),
  .reg_req_i(reg_req_i),
  .reg_rsp_o(reg_rsp_o),
  .event_mask_reg_i(event_mask_reg_i),
  .mbox_stat_o(mbox_stat_o),
  .event_enabled_o(event_enabled_o)
);

// *** imb_i2c_master.sv ***
/*
  imb_i2c_master: behavioural external i2c master that reaches the mailboxes.
  assumes: sda_i is the resolved wire with a pull-up; 800 ns link period.
*/
module imb_i2c_master #(
  parameter logic [6:0] ADDR = 7'h2a  // arbitrary, same as the slave default
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_nack = 0;  // bytes the slave failed to acknowledge
  // idle bus: clock stands still high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // a quarter of the link period
  task automatic q();
    repeat (2) @(posedge clk_i);
  endtask
  // one bit; data moves only while scl is low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    q();
    scl_o <= 1'b1;
    q();
    q();
    r = sda_i;
    scl_o <= 1'b0;
    q();
  endtask
  // start or repeated start
  task automatic start();
    sda_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_o <= 1'b0;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  // stop closes every transfer so that a read counts
  task automatic stop();
    sda_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_o <= 1'b1;
    q();
    q();
  endtask
  // byte out, msb first, then the slave's acknowledge slot
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    if (r !== 1'b0) n_nack++;
  endtask
  // byte in; the last byte of a read is not acknowledged
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'b1, r);
      d = {d[6:0], r};
    end
    bit_x(last, r);
  endtask
  // pointer then four data bytes, msb byte first
  task automatic mb_wr(input logic [7:0] ptr, input logic [31:0] w);
    start();
    put({ADDR, 1'b0});
    put(ptr);
    for (int i = 3; i >= 0; i--) put(w[i*8 +: 8]);
    stop();
  endtask
  // pointer, repeated start, four bytes read back
  task automatic mb_rd(input logic [7:0] ptr, output logic [31:0] w);
    logic [7:0] b;
    start();
    put({ADDR, 1'b0});
    put(ptr);
    start();
    put({ADDR, 1'b1});
    for (int i = 3; i >= 0; i--) begin
      get(i == 0, b);
      w[i*8 +: 8] = b;
    end
    stop();
  endtask
  // pointer and data byte sent to another slave address; nobody should answer
  task automatic probe(input logic [6:0] a);
    start();
    put({a, 1'b0});
    put(8'h94);
    put(8'h5a);
    stop();
  endtask
endmodule

// *** test_i2c_mailbox_event_logic.sv ***
/*
  test_i2c_mailbox_event_logic: self-checking bench for the mailbox block.
  assumes: 10 mhz clock, behavioural i2c master on the pins, no random stimulus.
*/
module test_i2c_mailbox_event_logic import imb_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic srst = 1'b0;
  logic snap = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic sda_do;
  logic [31:0] clr = 32'h0;
  logic [31:0] mask = 32'hffffffff;
  logic [31:0] ext = 32'h0;
  logic [31:0] en;
  logic [31:0] n_drain = 32'h0;
  logic [31:0] n_load = 32'h0;
  imb_reg_req_t req = '0;
  imb_reg_rsp_t rsp;
  imb_mbox_stat_t stat;
  int n_mismatch = 0;
  int check_count = 0;
  wire sda = sda_m & ~sda_oe;  // open drain with pull-up
  imb_mailbox dut_u (.ref_clk_i(ref_clk), .reset_i(reset), .block_soft_reset_i(srst), .reg_req_i(req),
    .reg_rsp_o(rsp), .scl_i(scl), .sda_i(sda), .sda_o(sda_do), .sda_oe_o(sda_oe), .snap_capture_i(snap),
    .int_stat_clear_i(clr), .event_mask_reg_i(mask), .ext_event_i(ext), .mbox_stat_o(stat),
    .event_enabled_o(en));
  imb_i2c_master mst_u (.clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // count interrupt pulses so repeats are seen
  always @(posedge ref_clk) begin
    if (stat.outgoing_drained_irq === 1'b1) n_drain <= n_drain + 32'h1;
    if (stat.incoming_loaded_irq === 1'b1) n_load <= n_load + 32'h1;
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  // one bus access; answer taken the cycle after the request
  task automatic reg_io(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    req <= '{1'b1, w, a, d};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
    chkf(rsp.valid, 1'b1);
    r = rsp.rdata;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    reg_io(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] r;
    reg_io(1'b0, a, 32'h0, r);
    chk32(r, e);
  endtask
  // one-cycle pulses on the status side inputs
  task automatic side(input logic [31:0] e, input logic s, input logic [31:0] c);
    @(posedge ref_clk);
    ext <= e;
    snap <= s;
    clr <= c;
    @(posedge ref_clk);
    ext <= 32'h0;
    snap <= 1'b0;
    clr <= 32'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic t_reset();
    rdc(OFS_OUTBOUND, MBOX_RESET);
    rdc(OFS_INBOUND, MBOX_RESET);
    rdc(OFS_EV_SUMMARY, EVENT_RESET);
    rdc(OFS_EV_SNAPSHOT, EVENT_RESET);
    rdc(17'h1d2a0, 32'h0);
  endtask
  task automatic t_out();
    logic [31:0] w;
    wr(OFS_OUTBOUND, 32'ha1b2c3d4);
    chkf(stat.outgoing_full_flag, 1'b1);
    mst_u.mb_wr(I2C_OUT_FIRST, 32'h01020304);
    rdc(OFS_OUTBOUND, 32'ha1b2c3d4);
    chkf(stat.outgoing_full_flag, 1'b1);
    wr(OFS_EV_SUMMARY, 32'hffffffff);
    rdc(OFS_EV_SUMMARY, 32'h0);
    mst_u.mb_rd(I2C_OUT_FIRST, w);
    chk32(w, 32'ha1b2c3d4);
    chkf(sda_do, 1'b0);
    repeat (4) @(posedge ref_clk);
    chkf(stat.outgoing_full_flag, 1'b0);
    chk32(n_drain, 32'h1);
    rdc(OFS_EV_SUMMARY, 32'h20c);
    wr(OFS_EV_SUMMARY, 32'hffffffff);
    mst_u.mb_rd(I2C_OUT_FIRST, w);
    repeat (4) @(posedge ref_clk);
    chk32(n_drain, 32'h1);
    rdc(OFS_EV_SUMMARY, 32'h00c);
  endtask
  task automatic t_in();
    logic [31:0] w;
    wr(OFS_EV_SUMMARY, 32'hffffffff);
    mst_u.mb_wr(I2C_IN_FIRST, 32'h11223344);
    repeat (4) @(posedge ref_clk);
    chkf(stat.incoming_full_flag, 1'b1);
    chk32(n_load, 32'h1);
    wr(OFS_INBOUND, 32'hdeadbeef);
    rdc(OFS_INBOUND, 32'h11223344);
    chkf(stat.incoming_full_flag, 1'b0);
    rdc(OFS_EV_SUMMARY, 32'h10a);
    mst_u.mb_rd(I2C_IN_FIRST, w);
    chk32(w, 32'h11223344);
    chk32(mst_u.n_nack, 32'h0);
    mst_u.probe(7'h55);
    chk32(mst_u.n_nack, 32'h3);
    chkf(stat.incoming_full_flag, 1'b0);
    rdc(OFS_INBOUND, 32'h11223344);
  endtask
  task automatic t_snap();
    wr(OFS_EV_SUMMARY, 32'hffffffff);
    side(32'h20, 1'b0, 32'h0);
    side(32'h0, 1'b1, 32'h0);
    side(32'h40, 1'b0, 32'h0);
    rdc(OFS_EV_SNAPSHOT, 32'h20);
    rdc(OFS_EV_SUMMARY, 32'h60);
    chk32(en, 32'h60);
    wr(OFS_EV_SNAPSHOT, 32'h60);
    rdc(OFS_EV_SUMMARY, 32'h40);
    side(32'h20, 1'b1, 32'h0);
    side(32'h0, 1'b1, 32'h0);
    @(posedge ref_clk);
    mask <= 32'h40;
    side(32'h0, 1'b0, 32'h60);
    rdc(OFS_EV_SNAPSHOT, 32'h20);
    chk32(en, 32'h0);
    @(posedge ref_clk);
    mask <= 32'hffffffff;
  endtask
  task automatic t_srst();
    wr(OFS_OUTBOUND, 32'h5a5a5a5a);
    @(posedge ref_clk);
    srst <= 1'b1;
    ext <= 32'h20;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    ext <= 32'h0;
    rdc(OFS_EV_SUMMARY, 32'h0);
    rdc(OFS_EV_SNAPSHOT, 32'h0);
    chkf(stat.outgoing_full_flag, 1'b0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // the whole run is well under half a millisecond
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_out();
    t_in();
    t_snap();
    t_srst();
    end_of_test();
  end
endmodule
